/* rtl/apsc_top.sv */
`timescale 1ns/1ps
`include "apsc_defines.svh"
module apsc_top import apsc_pkg::*; #(
   parameter int STREAM_CYCLES = `APSC_STREAM_MS * (`APSC_CLK_HZ / 1000)
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   input wire logic signed [15:0] pressure,
   input wire logic ctrl_variant_pin,
   input wire logic rs485_variant_pin,
   output logic [15:0] uart_baud_div,
   output logic [15:0] p_gain,
   output logic [15:0] d_gain,
   output logic [15:0] setpoint,
   output logic [7:0] unit_addr,
   output logic streaming
);
   typedef struct packed {
      logic [1:0] ctl_sync;
      logic [1:0] r485_sync;
      logic [7:0] addr;
      logic [15:0] pgain;
      logic [15:0] dgain;
      logic [15:0] setpt;
      logic pend_v;
      apsc_job_t pend;
      logic due;
      logic [31:0] tmr;
      apsc_sst_t st;
      apsc_job_t job;
      logic seg;
      logic [2:0] idx;
      logic lead;
      logic [`APSC_LINE_LEN-1:0][7:0] lbuf;
      logic [3:0] wptr;
      logic [3:0] rptr;
      logic [7:0] txd;
      logic fstart;
   } apsc_top_st_t;

   apsc_top_st_t s_q, s_d;
   apsc_cmd_t cmd;
   logic cmd_valid;
   logic [`APSC_DIGITS-1:0][3:0] digs;
   logic fmt_done;
   logic is_ctl;
   logic is_485;
   logic strm;
   logic [3:0] dval;

   apsc_rx_parse u_parse (
      .core_clk(core_clk),
      .rst(rst),
      .rx_data(rx_data),
      .rx_valid(rx_valid),
      .cmd(cmd),
      .cmd_valid(cmd_valid)
   );

   apsc_dec_fmt u_fmt (
      .core_clk(core_clk),
      .rst(rst),
      .start(s_q.fstart),
      .value(s_q.seg ? s_q.job.val1 : s_q.job.val0),
      .digits(digs),
      .done(fmt_done)
   );

   // a data line snapshot: sign and magnitude of pressure, set-point for controllers
   function automatic apsc_job_t data_job(input logic signed [15:0] p, input logic ctl,
                                          input logic [15:0] sp);
      apsc_job_t j;
      j.pre0 = p[15] ? `APSC_CH_MINUS : `APSC_CH_PLUS;
      j.val0 = p[15] ? 16'(-p) : p;
      j.two = ctl;
      j.sep = `APSC_CH_SPACE;
      j.val1 = sp;
      j.pad = 1'b1;
      return j;
   endfunction

   // reply to a read or write: number, optionally '=' and a second number
   function automatic apsc_job_t num_job(input logic [15:0] a, input logic two,
                                         input logic [15:0] b);
      apsc_job_t j;
      j.pre0 = 8'h00;
      j.val0 = a;
      j.two = two;
      j.sep = `APSC_CH_EQ;
      j.val1 = b;
      j.pad = 1'b0;
      return j;
   endfunction

   // straps come from pins, so only the second sync stage is looked at
   assign is_ctl = s_q.ctl_sync[1];
   assign is_485 = s_q.r485_sync[1];
   assign strm = (s_q.addr == `APSC_ADDR_STREAM) && !is_485;
   assign dval = digs[s_q.idx];

   always_comb begin
      s_d = s_q;
      s_d.ctl_sync = {s_q.ctl_sync[0], ctrl_variant_pin};
      s_d.r485_sync = {s_q.r485_sync[0], rs485_variant_pin};
      s_d.fstart = 1'b0;

      // stream pacing: one line every period while streaming
      if (strm) begin
         if (s_q.tmr == 32'(STREAM_CYCLES - 1)) begin
            s_d.tmr = 32'h0000_0000;
            s_d.due = 1'b1;
         end else begin
            s_d.tmr = s_q.tmr + 32'h0000_0001;
         end
      end else begin
         s_d.tmr = 32'h0000_0000;
         s_d.due = 1'b0;
      end

      // reply sequencer: fill the line buffer, then shift it out
      unique case (s_q.st)
         S_IDLE: begin
            if (s_q.pend_v || s_q.due) begin
               s_d.job = s_q.pend_v ? s_q.pend : data_job(pressure, is_ctl, s_q.setpt);
               if (s_q.pend_v) begin
                  s_d.pend_v = 1'b0;
               end else begin
                  // a tick landing in the same cycle as the take must not be lost
                  s_d.due = strm && (s_q.tmr == 32'(STREAM_CYCLES - 1));
               end
               s_d.seg = 1'b0;
               s_d.wptr = 4'h0;
               s_d.st = S_CONV;
            end
         end
         S_CONV: begin
            if (s_q.seg) begin
               s_d.lbuf[s_q.wptr] = s_q.job.sep;
               s_d.wptr = s_q.wptr + 4'h1;
            end else if (s_q.job.pre0 != 8'h00) begin
               s_d.lbuf[s_q.wptr] = s_q.job.pre0;
               s_d.wptr = s_q.wptr + 4'h1;
            end
            s_d.fstart = 1'b1;
            s_d.lead = !s_q.job.pad;
            s_d.idx = 3'd0;
            s_d.st = S_WAIT;
         end
         S_WAIT: begin
            if (fmt_done) begin
               s_d.st = S_DIGS;
            end
         end
         S_DIGS: begin
            // leading zeros suppressed for replies, kept for fixed-width data lines
            if (!(s_q.lead && dval == 4'h0 && s_q.idx != 3'(`APSC_DIGITS - 1))) begin
               s_d.lbuf[s_q.wptr] = {4'h3, dval};
               s_d.wptr = s_q.wptr + 4'h1;
               s_d.lead = 1'b0;
            end
            s_d.idx = s_q.idx + 3'd1;
            if (s_q.idx == 3'(`APSC_DIGITS - 1)) begin
               if (!s_q.seg && s_q.job.two) begin
                  s_d.seg = 1'b1;
                  s_d.st = S_CONV;
               end else begin
                  s_d.st = S_TERM;
               end
            end
         end
         S_TERM: begin
            s_d.lbuf[s_q.wptr] = `APSC_CH_CR;
            s_d.wptr = s_q.wptr + 4'h1;
            s_d.rptr = 4'h0;
            s_d.txd = s_q.lbuf[0];
            s_d.st = S_SEND;
         end
         S_SEND: begin
            if (tx_ready) begin
               s_d.rptr = s_q.rptr + 4'h1;
               s_d.txd = s_q.lbuf[s_q.rptr + 4'h1];
               if (s_q.rptr + 4'h1 == s_q.wptr) begin
                  s_d.st = S_IDLE;
               end
            end
         end
         default: s_d.st = S_IDLE;
      endcase

      // command effects; a new reply overrides a taken one in the same cycle
      if (cmd_valid) begin
         unique case (cmd.kind)
            K_SETADDR: begin
               // no address filter: every unit on the line takes it, save that an rs485 unit refuses the at-sign
               if (cmd.letter != `APSC_ADDR_STREAM || !is_485) begin
                  s_d.addr = cmd.letter;
               end
            end
            K_READ: begin
               if (cmd.num_a == `APSC_REG_PGAIN) begin
                  s_d.pend = num_job(s_q.pgain, 1'b0, 16'h0000);
                  s_d.pend_v = 1'b1;
               end else if (cmd.num_a == `APSC_REG_DGAIN) begin
                  s_d.pend = num_job(s_q.dgain, 1'b0, 16'h0000);
                  s_d.pend_v = 1'b1;
               end
            end
            K_WRITE: begin
               if (cmd.num_a == `APSC_REG_PGAIN) begin
                  s_d.pgain = cmd.num_b;
                  s_d.pend = num_job(cmd.num_a, 1'b1, cmd.num_b);
                  s_d.pend_v = 1'b1;
               end else if (cmd.num_a == `APSC_REG_DGAIN) begin
                  s_d.dgain = cmd.num_b;
                  s_d.pend = num_job(cmd.num_a, 1'b1, cmd.num_b);
                  s_d.pend_v = 1'b1;
               end
            end
            K_POLL: begin
               if (cmd.letter == s_q.addr) begin
                  s_d.pend = data_job(pressure, is_ctl, s_q.setpt);
                  s_d.pend_v = 1'b1;
               end
            end
            K_SETPT: begin
               // a bare number is accepted only while streaming
               if (cmd.letter == s_q.addr || (cmd.letter == 8'h00 && strm)) begin
                  s_d.setpt = cmd.num_b;
               end
            end
            default: s_d.pend_v = s_d.pend_v;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.addr <= `APSC_ADDR_RST;
         s_q.pgain <= `APSC_PGAIN_RST;
         s_q.dgain <= `APSC_DGAIN_RST;
         s_q.setpt <= `APSC_SETPT_RST;
         s_q.st <= S_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs; the external uart takes its divisor from here
   assign uart_baud_div = 16'(`APSC_CLK_HZ / `APSC_BAUD);
   assign tx_data = s_q.txd;
   assign tx_valid = (s_q.st == S_SEND);
   assign p_gain = s_q.pgain;
   assign d_gain = s_q.dgain;
   assign setpoint = s_q.setpt;
   assign unit_addr = s_q.addr;
   assign streaming = strm;
endmodule

/* rtl/apsc_defines.svh */
`ifndef APSC_DEFINES_SVH
`define APSC_DEFINES_SVH
// register numbers and reset values
`define APSC_REG_PGAIN 16'h0015
`define APSC_REG_DGAIN 16'h0016
`define APSC_PGAIN_RST 16'h0000
`define APSC_DGAIN_RST 16'h0000
`define APSC_SETPT_RST 16'h0000
// address letters
`define APSC_ADDR_RST 8'h41
`define APSC_ADDR_STREAM 8'h40
`define APSC_LET_Z 8'h5a
// characters of the command and reply syntax
`define APSC_CH_STAR 8'h2a
`define APSC_CH_EQ 8'h3d
`define APSC_CH_CR 8'h0d
`define APSC_CH_SPACE 8'h20
`define APSC_CH_PLUS 8'h2b
`define APSC_CH_MINUS 8'h2d
`define APSC_CH_ZERO 8'h30
`define APSC_CH_NINE 8'h39
`define APSC_CH_RD_UC 8'h52
`define APSC_CH_RD_LC 8'h72
`define APSC_CH_WR_UC 8'h57
`define APSC_CH_WR_LC 8'h77
// timing
`define APSC_CLK_HZ 20000000
`define APSC_STREAM_MS 50
`define APSC_BAUD 19200
// sizes
`define APSC_DIGITS 5
`define APSC_LINE_LEN 16
`endif

/* rtl/apsc_pkg.sv */
package apsc_pkg;
   // command kinds reported by the line parser
   typedef enum logic [2:0] {
      K_NONE, K_SETADDR, K_READ, K_WRITE, K_POLL, K_SETPT
   } apsc_kind_t;

   typedef struct packed {
      apsc_kind_t kind;
      logic [7:0] letter;
      logic [15:0] num_a;
      logic [15:0] num_b;
   } apsc_cmd_t;

   // one reply line: optional prefix, value, optional separator and second value
   typedef struct packed {
      logic [15:0] val0;
      logic [15:0] val1;
      logic [7:0] pre0;
      logic [7:0] sep;
      logic two;
      logic pad;
   } apsc_job_t;

   typedef enum logic [3:0] {
      P_START = 4'h0, P_STAR = 4'h1, P_AT = 4'h3, P_ATEQ = 4'h2, P_ATLET = 4'h6,
      P_REG = 4'h7, P_VAL = 4'h5, P_LET = 4'h4, P_LNUM = 4'hc, P_NUM = 4'hd,
      P_BAD = 4'hf
   } apsc_pst_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_CONV = 3'h1, S_WAIT = 3'h3, S_DIGS = 3'h2, S_TERM = 3'h6,
      S_SEND = 3'h7
   } apsc_sst_t;
endpackage

/* rtl/apsc_rx_parse.sv */
`timescale 1ns/1ps
`include "apsc_defines.svh"
module apsc_rx_parse import apsc_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   output apsc_cmd_t cmd,
   output logic cmd_valid
);
   typedef struct packed {
      apsc_pst_t st;
      logic wr;
      logic dig;
      logic ovf;
      logic [15:0] acc;
      apsc_cmd_t cmd;
      logic vld;
   } apsc_prs_t;

   apsc_prs_t s_q, s_d;
   logic is_dig;
   logic is_let;
   logic in_num;
   logic [20:0] prod;

   // characters are classified as they arrive; nothing acts before the line end
   always_comb begin
      s_d = s_q;
      s_d.vld = 1'b0;
      is_dig = (rx_data >= `APSC_CH_ZERO) && (rx_data <= `APSC_CH_NINE);
      is_let = (rx_data >= `APSC_ADDR_RST) && (rx_data <= `APSC_LET_Z);
      in_num = (s_q.st == P_REG) || (s_q.st == P_VAL) || (s_q.st == P_LNUM)
         || (s_q.st == P_NUM);
      prod = {5'h00, s_q.acc} * 21'd10 + {17'h00000, rx_data[3:0]};
      if (rx_valid) begin
         if (rx_data == `APSC_CH_CR) begin
            s_d.st = P_START;
            s_d.cmd.kind = K_NONE;
            unique case (s_q.st)
               P_ATLET: s_d.cmd.kind = K_SETADDR;
               P_REG: begin
                  if (!s_q.wr && s_q.dig && !s_q.ovf) begin
                     s_d.cmd.kind = K_READ;
                     s_d.cmd.num_a = s_q.acc;
                  end
               end
               P_VAL: begin
                  if (s_q.dig && !s_q.ovf) begin
                     s_d.cmd.kind = K_WRITE;
                     s_d.cmd.num_b = s_q.acc;
                  end
               end
               P_LET: s_d.cmd.kind = K_POLL;
               P_LNUM, P_NUM: begin
                  if (!s_q.ovf) begin
                     s_d.cmd.kind = K_SETPT;
                     s_d.cmd.num_b = s_q.acc;
                  end
               end
               default: s_d.cmd.kind = K_NONE;
            endcase
            s_d.vld = (s_d.cmd.kind != K_NONE);
         end else if (is_dig && in_num) begin
            // 16-bit accumulate; anything above 65535 spoils the line
            s_d.acc = prod[15:0];
            s_d.ovf = s_q.ovf | (|prod[20:16]);
            s_d.dig = 1'b1;
         end else begin
            // backspace, delete and any stray byte fall through to a dead line
            s_d.st = P_BAD;
            s_d.acc = {12'h000, rx_data[3:0]};
            s_d.dig = 1'b1;
            s_d.ovf = 1'b0;
            unique case (s_q.st)
               P_START: begin
                  if (rx_data == `APSC_CH_STAR) begin
                     s_d.st = P_STAR;
                  end else if (is_let) begin
                     s_d.st = P_LET;
                     s_d.cmd.letter = rx_data;
                  end else if (is_dig) begin
                     s_d.st = P_NUM;
                     s_d.cmd.letter = 8'h00;
                  end
               end
               P_STAR: begin
                  s_d.acc = 16'h0000;
                  s_d.dig = 1'b0;
                  if (rx_data == `APSC_ADDR_STREAM) begin
                     s_d.st = P_AT;
                  end else if (rx_data == `APSC_CH_RD_UC || rx_data == `APSC_CH_RD_LC) begin
                     s_d.st = P_REG;
                     s_d.wr = 1'b0;
                  end else if (rx_data == `APSC_CH_WR_UC || rx_data == `APSC_CH_WR_LC) begin
                     s_d.st = P_REG;
                     s_d.wr = 1'b1;
                  end
               end
               P_AT: begin
                  if (rx_data == `APSC_CH_EQ) begin
                     s_d.st = P_ATEQ;
                  end
               end
               P_ATEQ: begin
                  if (is_let || rx_data == `APSC_ADDR_STREAM) begin
                     s_d.st = P_ATLET;
                     s_d.cmd.letter = rx_data;
                  end
               end
               P_REG: begin
                  if (rx_data == `APSC_CH_EQ && s_q.wr && s_q.dig && !s_q.ovf) begin
                     s_d.st = P_VAL;
                     s_d.cmd.num_a = s_q.acc;
                     s_d.acc = 16'h0000;
                     s_d.dig = 1'b0;
                  end
               end
               P_LET: begin
                  if (is_dig) begin
                     s_d.st = P_LNUM;
                  end
               end
               default: s_d.st = P_BAD;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cmd = s_q.cmd;
   assign cmd_valid = s_q.vld;
endmodule

/* rtl/apsc_dec_fmt.sv */
`timescale 1ns/1ps
`include "apsc_defines.svh"
module apsc_dec_fmt import apsc_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [15:0] value,
   output logic [`APSC_DIGITS-1:0][3:0] digits,
   output logic done
);
   typedef struct packed {
      logic busy;
      logic [2:0] idx;
      logic [15:0] rem;
      logic [3:0] cnt;
      logic [`APSC_DIGITS-1:0][3:0] digs;
      logic done;
   } apsc_fmt_t;

   apsc_fmt_t s_q, s_d;
   logic [15:0] pow;

   // repeated subtraction: slow but needs no divider, one number takes up to ~50 cycles
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      unique case (s_q.idx)
         3'd0: pow = 16'd10000;
         3'd1: pow = 16'd1000;
         3'd2: pow = 16'd100;
         3'd3: pow = 16'd10;
         default: pow = 16'd1;
      endcase
      if (start) begin
         s_d.busy = 1'b1;
         s_d.idx = 3'd0;
         s_d.rem = value;
         s_d.cnt = 4'h0;
      end else if (s_q.busy) begin
         if (s_q.rem >= pow) begin
            s_d.rem = s_q.rem - pow;
            s_d.cnt = s_q.cnt + 4'h1;
         end else begin
            s_d.digs[s_q.idx] = s_q.cnt;
            s_d.cnt = 4'h0;
            s_d.idx = s_q.idx + 3'd1;
            if (s_q.idx == 3'(`APSC_DIGITS - 1)) begin
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign digits = s_q.digs;
   assign done = s_q.done;
endmodule

/* bench/apsc_top_props.sv */
`timescale 1ns/1ps
module apsc_top_props import apsc_pkg::*; #(
   parameter int STREAM_CYCLES = 400
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic signed [15:0] pressure,
   input wire logic ctrl_variant_pin,
   input wire logic rs485_variant_pin,
   input wire logic [15:0] uart_baud_div,
   input wire logic [15:0] p_gain,
   input wire logic [15:0] d_gain,
   input wire logic [15:0] setpoint,
   input wire logic [7:0] unit_addr,
   input wire logic streaming
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // state may only move two edges after a carriage return was taken
   a_addr_legal: assert property (unit_addr inside {[8'h41:8'h5a], 8'h40})
      else $error("unit address outside A to Z and at-sign");
   a_stream_at: assert property (streaming |-> unit_addr == 8'h40)
      else $error("streaming without at-sign address");
   a_rs485_quiet: assert property (rs485_variant_pin [*3] |-> !streaming)
      else $error("rs485 variant streams");
   a_addr_on_cr: assert property ($changed(unit_addr) |->
      $past(rx_valid && rx_data == 8'h0d, 2))
      else $error("address moved without a line end");
   a_pgain_on_cr: assert property ($changed(p_gain) |->
      $past(rx_valid && rx_data == 8'h0d, 2))
      else $error("proportional gain moved without a line end");
   a_dgain_on_cr: assert property ($changed(d_gain) |->
      $past(rx_valid && rx_data == 8'h0d, 2))
      else $error("derivative gain moved without a line end");
   a_setpt_on_cr: assert property ($changed(setpoint) |->
      $past(rx_valid && rx_data == 8'h0d, 2))
      else $error("set-point moved without a line end");
   // a stalled host must see the same byte until it takes it
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("offered byte dropped or changed");
   a_line_end: assert property (tx_valid && tx_ready && tx_data == 8'h0d |=>
      !tx_valid [*3])
      else $error("byte offered right after line end");
   a_baud_fixed: assert property (uart_baud_div == 16'h0411)
      else $error("baud divisor wrong");
   c_stream: cover property ($rose(streaming));
   c_gain: cover property ($changed(p_gain));
   c_stall_end: cover property (tx_valid && !tx_ready ##1 tx_ready && tx_data == 8'h0d);
endmodule

/* bench/apsc_host_model.sv */
`timescale 1ns/1ps
module apsc_host_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic stall_en,
   output logic [7:0] got_byte,
   output logic got
);
   initial tx_ready = 1'b0;
   // whole 8-bit characters, one per handshake, as an 8N1 receiver delivers them
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         got <= 1'b0;
         got_byte <= 8'h00;
      end else begin
         got <= tx_valid && tx_ready;
         got_byte <= tx_data;
      end
   end
   // a slow terminal stalls at random; ready moves only after the falling edge
   always @(negedge core_clk) begin
      tx_ready <= stall_en ? 1'($urandom_range(1, 0)) : 1'b1;
   end
endmodule

/* bench/apsc_top_tb.sv */
`timescale 1ns/1ps
module apsc_top_tb;
   localparam int STREAM_N = 400;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] rx_data = 8'h00;
   logic rx_valid = 1'b0;
   logic stall_en = 1'b0;
   logic signed [15:0] pressure = 16'sh0000;
   logic ctrl_pin = 1'b0;
   logic rs485_pin = 1'b0;
   logic [7:0] tx_data, got_byte, unit_addr, s_exp;
   logic tx_valid, tx_ready, got, streaming;
   logic [15:0] baud, p_gain, d_gain, setpoint;
   int n_fail = 0;
   int n_checks = 0;
   int n_lines = 0;
   int s_idx = 0;
   bit stream_ok = 1'b0;
   string sline;
   logic [7:0] exp_q[$];

   always #25 core_clk = ~core_clk;

   apsc_top #(.STREAM_CYCLES(STREAM_N)) DUT (.core_clk(core_clk), .rst(rst),
      .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .pressure(pressure), .ctrl_variant_pin(ctrl_pin),
      .rs485_variant_pin(rs485_pin), .uart_baud_div(baud), .p_gain(p_gain),
      .d_gain(d_gain), .setpoint(setpoint), .unit_addr(unit_addr), .streaming(streaming));
   // a single unit on the line, so address commands reach only it
   apsc_host_model u_host (.core_clk(core_clk), .rst(rst), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .stall_en(stall_en),
      .got_byte(got_byte), .got(got));

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // bytes go back to back, valid held high, line closed by a carriage return
   task automatic send_line(input string s);
      for (int i = 0; i <= s.len(); i++) begin
         @(negedge core_clk);
         rx_valid = 1'b1;
         rx_data = (i < s.len()) ? s[i] : 8'h0d;
      end
      @(negedge core_clk);
      rx_valid = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask

   // note the reply first, then send; the quiet tail catches stray replies
   task automatic cmd(input string s, input string reply);
      int k;
      foreach (reply[i]) exp_q.push_back(reply[i]);
      if (reply != "") exp_q.push_back(8'h0d);
      send_line(s);
      for (k = 0; k < 4000 && exp_q.size() > 0; k++) @(negedge core_clk);
      if (k == 4000) begin
         n_fail++;
         $display("BAD reply wait expected 0 seen %0d", exp_q.size());
      end
      repeat (200) @(negedge core_clk);
   endtask

   function automatic string pline(input int p, input bit two, input int sp);
      string s;
      s = $sformatf("%s%05d", (p < 0) ? "-" : "+", (p < 0) ? -p : p);
      if (two) s = {s, $sformatf(" %05d", sp)};
      return s;
   endfunction

   // each byte taken by the host is matched to the oldest note or the stream line
   always @(negedge core_clk) begin
      if (got) begin
         if (exp_q.size() > 0) begin
            check("reply byte", {8'h00, exp_q.pop_front()}, {8'h00, got_byte});
         end else if (stream_ok) begin
            s_exp = (s_idx < sline.len()) ? sline[s_idx] : 8'h0d;
            check("stream byte", {8'h00, s_exp}, {8'h00, got_byte});
            s_idx = (s_exp == 8'h0d) ? 0 : s_idx + 1;
            if (s_exp == 8'h0d) n_lines++;
         end else begin
            n_fail++;
            $display("BAD tx byte expected none seen %h", got_byte);
         end
      end
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      n_fail++;
      $display("BAD run expected finish seen hang");
      tally_and_finish();
   end

   initial begin
      int pr;
      int gv;
      string bad[$];
      void'($urandom(32'h4f39));
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      check("addr", 16'h0041, {8'h00, unit_addr});
      check("stream", 16'h0000, {15'h0000, streaming});
      check("baud", 16'h0411, baud);
      check("gains", 16'h0000, p_gain | d_gain | setpoint);
      cmd("*R21", "0");
      cmd("*W21=220", "21=220");
      check("p_gain", 16'h00dc, p_gain);
      gv = $urandom_range(65535, 1);
      cmd($sformatf("*w22=%0d", gv), $sformatf("22=%0d", gv));
      cmd("*r22", $sformatf("%0d", gv));
      check("d_gain", 16'(gv), d_gain);
      // editing keys, unmapped numbers, overflow, bad letters: all dropped
      bad = '{"*R21\010", "*R2\1771", "*R99", "*W21=70000", "*@=a", "*@=[", "Q", "*X21"};
      foreach (bad[i]) cmd(bad[i], "");
      check("p_gain kept", 16'h00dc, p_gain);
      check("addr kept", 16'h0041, {8'h00, unit_addr});
      stall_en = 1'b1;
      pr = $urandom_range(30000, 1);
      pressure = -16'(pr);
      cmd("A", pline(-pr, 1'b0, 0));
      cmd("A32000", "");
      check("setpoint", 16'h7d00, setpoint);
      cmd("A65535", "");
      check("setpoint max", 16'hffff, setpoint);
      cmd("A65536", "");
      check("setpoint kept", 16'hffff, setpoint);
      cmd("A32000", "");
      ctrl_pin = 1'b1;
      pressure = 16'(pr);
      cmd("A", pline(pr, 1'b1, 32000));
      cmd("*@=B", "");
      check("addr", 16'h0042, {8'h00, unit_addr});
      cmd("A", "");
      cmd("B", pline(pr, 1'b1, 32000));
      cmd("*@=A", "");
      rs485_pin = 1'b1;
      cmd("*@=@", "");
      check("rs485 stream", 16'h0000, {15'h0000, streaming});
      rs485_pin = 1'b0;
      ctrl_pin = 1'b0;
      sline = pline(pr, 1'b0, 0);
      stream_ok = 1'b1;
      cmd("*@=@", "");
      check("streaming", 16'h0001, {15'h0000, streaming});
      repeat (1200) @(negedge core_clk);
      check("stream lines", 16'h0001, {15'h0000, n_lines inside {[2:4]}});
      // a bare number is a set-point only while streaming
      send_line("16000");
      check("bare setpoint", 16'h3e80, setpoint);
      send_line("*@=A");
      check("polling", 16'h0000, {15'h0000, streaming});
      send_line("100");
      check("bare refused", 16'h3e80, setpoint);
      // let a line already under way finish, then nothing may arrive
      repeat (300) @(negedge core_clk);
      stream_ok = 1'b0;
      repeat (1200) @(negedge core_clk);
      tally_and_finish();
   end
endmodule

bind apsc_top apsc_top_props #(.STREAM_CYCLES(STREAM_CYCLES)) u_props (.core_clk(core_clk),
   .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .pressure(pressure),
   .ctrl_variant_pin(ctrl_variant_pin), .rs485_variant_pin(rs485_variant_pin),
   .uart_baud_div(uart_baud_div), .p_gain(p_gain), .d_gain(d_gain),
   .setpoint(setpoint), .unit_addr(unit_addr), .streaming(streaming));
